// >>> core/rate_div_pkg.sv
/*
 package for the data rate divider: register indices, field layout,
 reset values, preset tables and clock figures.
 assumes one core clock and an avalon-mm slave port with byte addresses.
*/
package rate_div_pkg;

    // core clock and master reference clock
    localparam int CORE_CLK_PERIOD_NS = 25;
    localparam int CORE_CLK_MHZ = 1000 / CORE_CLK_PERIOD_NS;
    localparam int MASTER_CLK_MHZ = 24;
    localparam int TX_PRESCALE = 10;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int TX_DIV_W = 12;
    localparam int RX_DIV1_W = 12;
    localparam int RX_DIV2_W = 7;
    localparam int PERIOD_W = 19;
    localparam int ACC_W = 26;

    // register indices; byte address is four times the index
    localparam logic [5:0] BANK1_BASE = 6'h10;
    localparam logic [5:0] IDX_CLOCK_SETUP_TWO = 6'h03;
    localparam logic [5:0] IDX_RATE_CODE_SELECT = 6'h06;
    localparam logic [5:0] IDX_RATE_STATUS = 6'h08;
    localparam logic [5:0] IDX_TX_DIVIDER_HIGH = BANK1_BASE + 6'h02;
    localparam logic [5:0] IDX_TX_DIVIDER_LOW = BANK1_BASE + 6'h03;
    localparam logic [5:0] IDX_RX_FIRST_DIVIDER_HIGH = BANK1_BASE + 6'h04;
    localparam logic [5:0] IDX_RX_FIRST_DIVIDER_LOW = BANK1_BASE + 6'h05;
    localparam logic [5:0] IDX_RX_SECOND_DIVIDER = BANK1_BASE + 6'h06;

    // field positions
    localparam int LOW_RATE_EN_BIT = 0;
    localparam int TX_CODE_LSB = 0;
    localparam int RX_CODE_LSB = 4;
    localparam int CODE_W = 4;

    // reset values
    localparam logic [REG_W-1:0] CLOCK_SETUP_TWO_RST = 8'h00;
    localparam logic [REG_W-1:0] RATE_CODE_SELECT_RST = 8'h00;
    localparam logic [TX_DIV_W-1:0] TX_DIV_RST = 12'h7D0;
    localparam logic [RX_DIV1_W-1:0] RX_DIV1_RST = 12'h0A0;
    localparam logic [RX_DIV2_W-1:0] RX_DIV2_RST = 7'h7D;

    typedef struct packed {
        logic [TX_DIV_W-1:0] tx_div;
        logic [RX_DIV1_W-1:0] rx_div1;
        logic [RX_DIV2_W-1:0] rx_div2;
    } divider_cfg_type;

    typedef struct packed {
        logic hit;
        logic [TX_DIV_W-1:0] tx_div;
    } tx_preset_type;

    typedef struct packed {
        logic hit;
        logic [RX_DIV1_W-1:0] rx_div1;
        logic [RX_DIV2_W-1:0] rx_div2;
    } rx_preset_type;

    // codes 0..9: 1.2, 2.4, 4.8, 9.6, 10.0, 19.2, 30.0 (rx 15.0), 32.768, 50, 100 kbps
    function automatic tx_preset_type tx_preset(input logic [CODE_W-1:0] code);
        tx_preset_type p;
        p.hit = 1'b1;
        case (code)
            4'h0: p.tx_div = 12'd2000;
            4'h1: p.tx_div = 12'd1000;
            4'h2: p.tx_div = 12'd500;
            4'h3: p.tx_div = 12'd250;
            4'h4: p.tx_div = 12'd240;
            4'h5: p.tx_div = 12'd125;
            4'h6: p.tx_div = 12'd80;
            4'h7: p.tx_div = 12'd73;
            4'h8: p.tx_div = 12'd48;
            4'h9: p.tx_div = 12'd24;
            default: begin
                p.hit = 1'b0;
                p.tx_div = 12'h000;
            end
        endcase
        return p;
    endfunction

    function automatic rx_preset_type rx_preset(input logic [CODE_W-1:0] code);
        rx_preset_type p;
        p.hit = 1'b1;
        case (code)
            4'h0: begin p.rx_div1 = 12'd160; p.rx_div2 = 7'd125; end
            4'h1: begin p.rx_div1 = 12'd80; p.rx_div2 = 7'd125; end
            4'h2: begin p.rx_div1 = 12'd40; p.rx_div2 = 7'd125; end
            4'h3: begin p.rx_div1 = 12'd20; p.rx_div2 = 7'd125; end
            4'h4: begin p.rx_div1 = 12'd20; p.rx_div2 = 7'd120; end
            4'h5: begin p.rx_div1 = 12'd10; p.rx_div2 = 7'd125; end
            4'h6: begin p.rx_div1 = 12'd16; p.rx_div2 = 7'd100; end
            4'h7: begin p.rx_div1 = 12'd6; p.rx_div2 = 7'd122; end
            4'h8: begin p.rx_div1 = 12'd8; p.rx_div2 = 7'd60; end
            4'h9: begin p.rx_div1 = 12'd4; p.rx_div2 = 7'd60; end
            default: begin
                p.hit = 1'b0;
                p.rx_div1 = 12'h000;
                p.rx_div2 = 7'h00;
            end
        endcase
        return p;
    endfunction

endpackage

// >>> core/symbol_strobe_gen.sv
/*
 fractional symbol strobe generator: one core-clock pulse every
 period master-clock ticks on average.
 assumes period is stable except when restart pulses.
*/
`timescale 1ns/100ps
module symbol_strobe_gen (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic restart_i,
    input wire logic [rate_div_pkg::PERIOD_W-1:0] period_i,
    output logic strobe_o
);
    import rate_div_pkg::*;

    localparam logic [ACC_W-1:0] STEP = ACC_W'(MASTER_CLK_MHZ);
    localparam logic [ACC_W-1:0] SCALE = ACC_W'(CORE_CLK_MHZ);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] acc_sum;
    logic [ACC_W-1:0] limit;

    // master ticks counted in units of core cycles, so the mean rate is exact
    assign acc_sum = acc_q + STEP;
    assign limit = ACC_W'(period_i) * SCALE;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            acc_q <= '0;
            strobe_o <= 1'b0;
        end else if (restart_i || period_i == '0) begin
            acc_q <= '0;
            strobe_o <= 1'b0;
        end else if (acc_sum >= limit) begin
            acc_q <= acc_sum - limit;
            strobe_o <= 1'b1;
        end else begin
            acc_q <= acc_sum;
            strobe_o <= 1'b0;
        end
    end

endmodule // symbol_strobe_gen

// >>> core/data_rate_divider.sv
/*
 data rate divider: transmit and receive symbol strobes derived from the
 24 MHz master rate, divider registers, rate code presets, avalon-mm slave.
 assumes avalon-mm master holds each request until waitrequest is low.
*/
`timescale 1ns/100ps
module data_rate_divider (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [rate_div_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [rate_div_pkg::DATA_W-1:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [rate_div_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic tx_symbol_strobe_o,
    output logic rx_symbol_strobe_o
);
    import rate_div_pkg::*;

    logic [REG_W-1:0] clock_setup_two_q;
    logic [REG_W-1:0] rate_code_select_q;
    divider_cfg_type cfg_q;
    logic tx_restart_q;
    logic rx_restart_q;
    logic tx_toggle_q;
    logic rx_toggle_q;
    logic tx_strobe;
    logic rx_strobe;

    logic [5:0] index;
    logic wr_take;
    logic rd_take;
    logic lane0;
    logic [REG_W-1:0] wbyte;
    logic low_rate_en;
    tx_preset_type tx_p;
    rx_preset_type rx_p;
    logic [REG_W-1:0] rd_mux;
    logic [PERIOD_W-1:0] tx_period;
    logic [PERIOD_W-1:0] rx_period;

    assign index = avs_address_i[ADDR_W-1:2];
    // a write completes at the edge where waitrequest is seen low; a read is taken at the request edge
    assign wr_take = avs_write_i && !avs_waitrequest_o;
    assign rd_take = avs_read_i && avs_waitrequest_o;
    assign lane0 = avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[REG_W-1:0];
    assign low_rate_en = clock_setup_two_q[LOW_RATE_EN_BIT];
    assign tx_p = tx_preset(wbyte[TX_CODE_LSB +: CODE_W]);
    assign rx_p = rx_preset(wbyte[RX_CODE_LSB +: CODE_W]);

    // bus handshake: one wait cycle, then a single acknowledge cycle
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
        end else if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
            avs_waitrequest_o <= 1'b0;
        end else begin
            avs_waitrequest_o <= 1'b1;
        end
    end

    always_comb begin
        rd_mux = '0;
        case (index)
            IDX_CLOCK_SETUP_TWO: rd_mux = clock_setup_two_q;
            IDX_RATE_CODE_SELECT: rd_mux = rate_code_select_q;
            IDX_RATE_STATUS: rd_mux = {5'h00, rx_toggle_q, tx_toggle_q, low_rate_en};
            IDX_TX_DIVIDER_HIGH: rd_mux = {4'h0, cfg_q.tx_div[TX_DIV_W-1:REG_W]};
            IDX_TX_DIVIDER_LOW: rd_mux = cfg_q.tx_div[REG_W-1:0];
            IDX_RX_FIRST_DIVIDER_HIGH: rd_mux = {4'h0, cfg_q.rx_div1[RX_DIV1_W-1:REG_W]};
            IDX_RX_FIRST_DIVIDER_LOW: rd_mux = cfg_q.rx_div1[REG_W-1:0];
            IDX_RX_SECOND_DIVIDER: rd_mux = {1'b0, cfg_q.rx_div2};
            default: rd_mux = '0;
        endcase
    end

    // read data registered at the request edge, valid while waitrequest is low
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_readdata_o <= '0;
        end else if (rd_take) begin
            avs_readdata_o <= {{(DATA_W-REG_W){1'b0}}, rd_mux};
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            clock_setup_two_q <= CLOCK_SETUP_TWO_RST;
        end else if (wr_take && lane0 && index == IDX_CLOCK_SETUP_TWO) begin
            clock_setup_two_q <= wbyte;
        end
    end

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rate_code_select_q <= RATE_CODE_SELECT_RST;
        end else if (wr_take && lane0 && index == IDX_RATE_CODE_SELECT) begin
            rate_code_select_q <= wbyte;
        end
    end

    // tx divider: direct writes, or preset on a code write in low-rate mode
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_q.tx_div <= TX_DIV_RST;
            tx_restart_q <= 1'b0;
        end else begin
            tx_restart_q <= 1'b0;
            if (wr_take && lane0) begin
                case (index)
                    IDX_TX_DIVIDER_HIGH: begin
                        cfg_q.tx_div[TX_DIV_W-1:REG_W] <= wbyte[TX_DIV_W-REG_W-1:0];
                        tx_restart_q <= 1'b1;
                    end
                    IDX_TX_DIVIDER_LOW: begin
                        cfg_q.tx_div[REG_W-1:0] <= wbyte;
                        tx_restart_q <= 1'b1;
                    end
                    IDX_RATE_CODE_SELECT: begin
                        if (low_rate_en && tx_p.hit) begin
                            cfg_q.tx_div <= tx_p.tx_div;
                            tx_restart_q <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // rx dividers: a code write outside low-rate mode leaves them alone
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cfg_q.rx_div1 <= RX_DIV1_RST;
            cfg_q.rx_div2 <= RX_DIV2_RST;
            rx_restart_q <= 1'b0;
        end else begin
            rx_restart_q <= 1'b0;
            if (wr_take && lane0) begin
                case (index)
                    IDX_RX_FIRST_DIVIDER_HIGH: begin
                        cfg_q.rx_div1[RX_DIV1_W-1:REG_W] <= wbyte[RX_DIV1_W-REG_W-1:0];
                        rx_restart_q <= 1'b1;
                    end
                    IDX_RX_FIRST_DIVIDER_LOW: begin
                        cfg_q.rx_div1[REG_W-1:0] <= wbyte;
                        rx_restart_q <= 1'b1;
                    end
                    IDX_RX_SECOND_DIVIDER: begin
                        cfg_q.rx_div2 <= wbyte[RX_DIV2_W-1:0];
                        rx_restart_q <= 1'b1;
                    end
                    IDX_RATE_CODE_SELECT: begin
                        if (low_rate_en && rx_p.hit) begin
                            cfg_q.rx_div1 <= rx_p.rx_div1;
                            cfg_q.rx_div2 <= rx_p.rx_div2;
                            rx_restart_q <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // changing rates mid-frame glitches one symbol; software avoids it
    assign tx_period = PERIOD_W'(cfg_q.tx_div * TX_PRESCALE);
    // widen before the product: a 12-bit product would wrap for the slow presets
    assign rx_period = PERIOD_W'(cfg_q.rx_div1) * PERIOD_W'(cfg_q.rx_div2);

    symbol_strobe_gen tx_gen (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .restart_i(tx_restart_q),
        .period_i(tx_period),
        .strobe_o(tx_strobe)
    );

    symbol_strobe_gen rx_gen (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .restart_i(rx_restart_q),
        .period_i(rx_period),
        .strobe_o(rx_strobe)
    );

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_symbol_strobe_o <= 1'b0;
            rx_symbol_strobe_o <= 1'b0;
        end else begin
            tx_symbol_strobe_o <= tx_strobe;
            rx_symbol_strobe_o <= rx_strobe;
        end
    end

    // status toggles let software see the chains running without polling pulses
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_toggle_q <= 1'b0;
            rx_toggle_q <= 1'b0;
        end else begin
            tx_toggle_q <= tx_toggle_q ^ tx_strobe;
            rx_toggle_q <= rx_toggle_q ^ rx_strobe;
        end
    end

endmodule // data_rate_divider

// >>> sim/rate_div_properties.sv
/*
 checker for the data rate divider: bus handshake, readback, strobe shape.
 assumes it is bound to the top module and that there is one clock domain.
*/
`timescale 1ns/100ps
module rate_div_properties import rate_div_pkg::*; (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [rate_div_pkg::DATA_W-1:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic tx_symbol_strobe_o,
    input wire logic rx_symbol_strobe_o
);
    logic [4:0] tx_gap_q;
    logic tx_seen_q;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // saturating gap counter; fastest tx rate still leaves 16 cycles
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tx_gap_q <= 5'h00;
            tx_seen_q <= 1'b0;
        end else if (tx_symbol_strobe_o) begin
            tx_gap_q <= 5'h00;
            tx_seen_q <= 1'b1;
        end else if (tx_gap_q != 5'h1F) begin
            tx_gap_q <= tx_gap_q + 5'h01;
        end
    end
    sequence s_taken;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_answer;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    property p_access; s_taken |=> s_answer; endproperty
    property p_idle; !(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o; endproperty
    property p_fell; $fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i); endproperty
    property p_hold; !(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o); endproperty
    property p_upper; avs_readdata_o[31:8] == '0; endproperty
    property p_tx_single; tx_symbol_strobe_o |=> !tx_symbol_strobe_o; endproperty
    property p_rx_single; rx_symbol_strobe_o |=> !rx_symbol_strobe_o; endproperty
    property p_tx_gap; tx_symbol_strobe_o && tx_seen_q |-> tx_gap_q >= 5'h0F; endproperty
    a_access: assert property (p_access) else $error("access not answered in one cycle");
    a_idle: assert property (p_idle) else $error("waitrequest dropped while idle");
    a_fell: assert property (p_fell) else $error("answer without a request");
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    a_tx_single: assert property (p_tx_single) else $error("tx strobe longer than one cycle");
    a_rx_single: assert property (p_rx_single) else $error("rx strobe longer than one cycle");
    a_tx_gap: assert property (p_tx_gap) else $error("tx strobes too close");
endmodule // rate_div_properties

bind data_rate_divider rate_div_properties u_props (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .tx_symbol_strobe_o(tx_symbol_strobe_o),
    .rx_symbol_strobe_o(rx_symbol_strobe_o)
);

// >>> sim/testbench.sv
/*
 self-checking bench for the data rate divider: registers, presets, strobe rates.
 assumes the avalon-mm slave answers with waitrequest low, strobes one cycle long.
*/
`timescale 1ns/100ps
module testbench;
    import rate_div_pkg::*;
    localparam int TXT [10] = '{2000, 1000, 500, 250, 240, 125, 80, 73, 48, 24};
    localparam int R1T [10] = '{160, 80, 40, 20, 20, 10, 16, 6, 8, 4};
    localparam int R2T [10] = '{125, 125, 125, 125, 120, 125, 100, 122, 60, 60};
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [DATA_W-1:0] avs_writedata_i = '0;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [DATA_W-1:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic tx_symbol_strobe_o;
    logic rx_symbol_strobe_o;
    int n_mismatch = 0;
    int n_compared = 0;
    int seed = 30761;
    int tx;
    int r1;
    int r2;
    logic [7:0] q;
    data_rate_divider uut (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .tx_symbol_strobe_o(tx_symbol_strobe_o),
        .rx_symbol_strobe_o(rx_symbol_strobe_o)
    );
    initial begin
        forever #(CORE_CLK_PERIOD_NS / 2.0) core_clk_i = ~core_clk_i;
    end
    task automatic results();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // upper write data random: only the low byte may matter
    task automatic bus(input logic rd, input logic [5:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address_i <= {idx, 2'b00};
        avs_read_i <= rd;
        avs_write_i <= ~rd;
        avs_writedata_i <= {24'($random(seed)), d};
        avs_byteenable_i <= be;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 20);
        q = avs_readdata_o[7:0];
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge core_clk_i);
        if (n >= 20) begin
            n_mismatch++;
            results();
        end
    endtask
    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        bus(1'b0, idx, d, 4'h1);
    endtask
    task automatic rd(input string name, input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b1, idx, 8'h00, 4'h0);
        chk(name, exp, q);
    endtask
    task automatic divs(input int t, input int a, input int b);
        rd("tx_high", IDX_TX_DIVIDER_HIGH, 8'(t >> 8));
        rd("tx_low", IDX_TX_DIVIDER_LOW, 8'(t));
        rd("rx1_high", IDX_RX_FIRST_DIVIDER_HIGH, 8'(a >> 8));
        rd("rx1_low", IDX_RX_FIRST_DIVIDER_LOW, 8'(a));
        rd("rx2", IDX_RX_SECOND_DIVIDER, 8'(b));
    endtask
    task automatic near(input string name, input int exp, input int got, input int tol);
        n_compared++;
        if (got < exp - tol || got > exp + tol) begin
            n_mismatch++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    task automatic meas(input logic is_rx, input int k, input int lim, output int cyc);
        int got;
        got = 0;
        cyc = 0;
        while (got < k && cyc < lim) begin
            @(posedge core_clk_i);
            cyc++;
            if ((is_rx ? rx_symbol_strobe_o : tx_symbol_strobe_o) === 1'b1) begin
                got++;
            end
        end
        if (got < k) begin
            n_mismatch++;
            results();
        end
    endtask
    // first strobe only roughly placed: restart and output register add latency
    task automatic rate(input logic is_rx, input int period);
        int c;
        int e;
        e = period * CORE_CLK_MHZ / MASTER_CLK_MHZ;
        meas(is_rx, 1, 4 * e + 50, c);
        near("first strobe", e, c, 3);
        meas(is_rx, 3, 12 * e + 50, c);
        near("three strobes", 3 * period * CORE_CLK_MHZ / MASTER_CLK_MHZ, c, 1);
    endtask
    initial begin
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        divs(2000, 160, 125);
        rd("clock_setup_two", IDX_CLOCK_SETUP_TWO, 8'h00);
        rd("rate_code_select", IDX_RATE_CODE_SELECT, 8'h00);
        rd("unmapped", 6'h3F, 8'h00);
        $display("test reset done");
        wr(IDX_CLOCK_SETUP_TWO, 8'h01);
        // rx code reversed so a swapped nibble shows
        for (int c = 0; c < 10; c++) begin
            wr(IDX_RATE_CODE_SELECT, 8'(((9 - c) << 4) | c));
            divs(TXT[c], R1T[9 - c], R2T[9 - c]);
        end
        wr(IDX_RATE_CODE_SELECT, 8'hFA);
        divs(TXT[9], R1T[0], R2T[0]);
        $display("test presets done");
        wr(IDX_CLOCK_SETUP_TWO, 8'h00);
        wr(IDX_RATE_CODE_SELECT, 8'h55);
        divs(TXT[9], R1T[0], R2T[0]);
        rd("rate_code_select", IDX_RATE_CODE_SELECT, 8'h55);
        bus(1'b0, IDX_TX_DIVIDER_LOW, 8'h11, 4'hE);
        wr(6'h3F, 8'hA5);
        rd("unmapped", 6'h3F, 8'h00);
        divs(TXT[9], R1T[0], R2T[0]);
        bus(1'b1, IDX_RATE_STATUS, 8'h00, 4'h0);
        chk("status_low_rate", 32'h0000_0000, {31'h0000_0000, q[LOW_RATE_EN_BIT]});
        $display("test refusals done");
        // rates change only while nothing is being sent or received
        for (int i = 0; i < 4; i++) begin
            tx = (i == 0) ? 260 : 1 + {$random(seed)} % 63;
            r1 = (i == 0) ? 257 : 1 + {$random(seed)} % 15;
            r2 = (i == 0) ? 2 : 2 + {$random(seed)} % 30;
            wr(IDX_TX_DIVIDER_HIGH, 8'(tx >> 8));
            wr(IDX_TX_DIVIDER_LOW, 8'(tx));
            rate(1'b0, tx * TX_PRESCALE);
            wr(IDX_RX_FIRST_DIVIDER_HIGH, 8'(r1 >> 8));
            wr(IDX_RX_FIRST_DIVIDER_LOW, 8'(r1));
            wr(IDX_RX_SECOND_DIVIDER, 8'(r2));
            rate(1'b1, r1 * r2);
        end
        $display("test strobe rates done");
        results();
    end
endmodule // testbench
